// ---- bss_cfg.svh ----
// constants for the buck soft-start and fault sequencer
`ifndef BSS_CFG_SVH
`define BSS_CFG_SVH
`define BSS_CLK_MHZ 250
`define BSS_QUAL_NS 5000
`define BSS_QUAL_CYC ((`BSS_QUAL_NS * `BSS_CLK_MHZ) / 1000)
`define BSS_NOC_WAIT_NS 2500
`define BSS_NOC_WAIT_CYC ((`BSS_NOC_WAIT_NS * `BSS_CLK_MHZ) / 1000)
`define BSS_NOC_SENSE_NS 300
`define BSS_NOC_SENSE_CYC ((`BSS_NOC_SENSE_NS * `BSS_CLK_MHZ + 999) / 1000)
`define BSS_MINOFF_NS 400
`define BSS_MINOFF_CYC ((`BSS_MINOFF_NS * `BSS_CLK_MHZ + 999) / 1000)
`define BSS_PHASE_CYCLES 110
`define BSS_CURRENT_LIMIT_SETTING_25 2'h0
`define BSS_CURRENT_LIMIT_SETTING_50 2'h1
`define BSS_CURRENT_LIMIT_SETTING_75 2'h2
`define BSS_CURRENT_LIMIT_SETTING_100 2'h3
`endif

// ---- bss_pkg.sv ----
// types for the buck soft-start and fault sequencer
package bss_pkg;
  typedef enum logic [4:0] {
    BSS_LOCK = 5'h01,
    BSS_IDLE = 5'h02,
    BSS_SOFT = 5'h04,
    BSS_RUN = 5'h08,
    BSS_FAULT = 5'h10
  } bss_state_e;
  typedef enum logic [2:0] {
    BSS_OFF = 3'h1,
    BSS_HIGH = 3'h2,
    BSS_LOW = 3'h4
  } bss_drive_e;
endpackage

// ---- bss_sequencer.sv ----
// soft-start, fault latch, power-good and gate drive sequencer for a buck controller
// Function
// - low-side on and phase above negative threshold turns low-side off
// - after negative turn-off wait 2.5us, then low-side 300ns to resense, repeat
// - output-ok low when output over 16% high or 10% low
// - output-ok held low until soft-start done and output at 90%
// - output-ok window and 90% changes qualified for 5us; fault latch or leaving run drops it at once
// - over-voltage latches low-side on and controller off
// - over-voltage must persist 5us before latching
// - under-voltage 30% low tri-states drives and latches controller off
// - under-voltage must persist 5us before latching
// - latched faults clear only on supply or enable toggle
// - power-on clear when supply above 3V
// - lockout blocks switching until supply above 4.2V
// - leaving lockout clears fault latch and soft-start counter; switch if enabled
// - first drive pulse after enabling is low-side
// - four phases of 110 cycles at 25, 50, 75, 100 percent limit
// - first phase doubles minimum off-time and adds 120mV sense offset
// - under-voltage and output-ok monitoring enabled after fourth phase
// - supply falling to 4.1V shuts down and tri-states both drives
// - high-side waits until low-side drive sensed off
// - low-side waits until phase node below 1V
// - high-side weak pull-up, strong pull-up added at phase 1.5V
// - minimum off-time enforced after each on-time
// - enable low shuts output down and turns on soft discharge
// - valley current over limit keeps high-side off
`timescale 1ns/1ns
`default_nettype none
`include "bss_cfg.svh"
module bss_sequencer
#(
  parameter int QUAL_CYC = `BSS_QUAL_CYC,
  parameter int PHASE_CYC = `BSS_PHASE_CYCLES
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic supplyPorOk,
  input wire logic supplyAboveOn,
  input wire logic supplyAboveOff,
  input wire logic enablePin,
  input wire logic onTimeRequest,
  input wire logic onTimeDone,
  input wire logic overVoltage,
  input wire logic underVoltage,
  input wire logic outOfWindow,
  input wire logic outputAt90,
  input wire logic phaseNegOc,
  input wire logic phaseBelow1v,
  input wire logic phaseAbove1v5,
  input wire logic lowGateAbove1v,
  input wire logic valleyOverLimit,
  output logic highGateDrive,
  output logic highGateStrong,
  output logic lowGateDrive,
  output logic drivesTriState,
  output logic outputOkFlag,
  output logic softDischarge,
  output logic biasOn,
  output logic [1:0] currentLimitScale,
  output logic doubleMinOff,
  output logic senseOffsetOn,
  output logic ovLatched,
  output logic uvLatched
);
  import bss_pkg::*;

  // ==========================================================
  // power-on clear, lockout and fault states
  bss_state_e state_r;
  bss_drive_e drive_r;
  logic [15:0] ovCnt_r, uvCnt_r, okCnt_r, nocCnt_r, offCnt_r;
  logic [8:0] cycCnt_r;
  logic [1:0] phase_r;
  logic nocWait_r, nocSense_r, firstPulse_r;
  logic okTarget, cycleEnd, ovQual, uvQual, running, ovNxt, uvNxt, hsHandoff;

  // qualification counter clears when the condition drops so a noisy edge restarts the delay, and saturates at the limit
  function automatic logic [15:0] bss_qual(input logic cond, input logic [15:0] cnt);
    if (!cond)
      return 16'h0;
    else if (cnt < 16'(QUAL_CYC))
      return cnt + 16'h1;
    else
      return cnt;
  endfunction

  assign ovQual = (ovCnt_r == 16'(QUAL_CYC));
  assign uvQual = (uvCnt_r == 16'(QUAL_CYC));
  assign cycleEnd = (drive_r == BSS_HIGH) && onTimeDone;
  assign running = (state_r == BSS_SOFT) || (state_r == BSS_RUN);
  // gate outputs use the latch next values so they never lag the fault flags
  assign ovNxt = running ? ovQual : (state_r == BSS_FAULT) && ovLatched;
  assign uvNxt = running ? (uvQual && !ovQual) : (state_r == BSS_FAULT) && uvLatched;
  assign hsHandoff = (drive_r == BSS_LOW) && !nocWait_r && !nocSense_r && !phaseNegOc
    && (offCnt_r == 16'h0) && onTimeRequest && !valleyOverLimit && !firstPulse_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      biasOn <= 1'b0;
    else
      biasOn <= supplyPorOk;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovCnt_r <= 16'h0;
      uvCnt_r <= 16'h0;
    end
    else
    begin
      ovCnt_r <= bss_qual(overVoltage && state_r != BSS_FAULT, ovCnt_r);
      uvCnt_r <= bss_qual(underVoltage && state_r == BSS_RUN, uvCnt_r);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= BSS_LOCK;
    else
    begin
      case (state_r)
        BSS_LOCK:
          if (supplyPorOk && supplyAboveOn)
            state_r <= BSS_IDLE;
        BSS_IDLE:
          if (!supplyAboveOff)
            state_r <= BSS_LOCK;
          else if (enablePin)
            state_r <= BSS_SOFT;
        BSS_SOFT, BSS_RUN:
          if (!supplyAboveOff || !supplyPorOk)
            state_r <= BSS_LOCK;
          else if (!enablePin)
            state_r <= BSS_IDLE;
          else if (ovQual || uvQual)
            state_r <= BSS_FAULT;
          else if (state_r == BSS_SOFT && phase_r == 2'h3 && cycleEnd
                   && cycCnt_r == 9'(PHASE_CYC - 1))
            state_r <= BSS_RUN;
        BSS_FAULT:
          if (!supplyAboveOff || !supplyPorOk)
            state_r <= BSS_LOCK;
          else if (!enablePin)
            state_r <= BSS_IDLE;
        default:
          state_r <= BSS_LOCK;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ovLatched <= 1'b0;
      uvLatched <= 1'b0;
    end
    else
    begin
      ovLatched <= ovNxt;
      uvLatched <= uvNxt;
    end
  end

  // ==========================================================
  // soft-start phase counter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cycCnt_r <= 9'h0;
      phase_r <= 2'h0;
    end
    else if (state_r != BSS_SOFT && state_r != BSS_RUN)
    begin
      cycCnt_r <= 9'h0;
      phase_r <= 2'h0;
    end
    else if (state_r == BSS_SOFT && cycleEnd)
    begin
      if (cycCnt_r == 9'(PHASE_CYC - 1))
      begin
        cycCnt_r <= 9'h0;
        if (phase_r != 2'h3)
          phase_r <= phase_r + 2'h1;
      end
      else
        cycCnt_r <= cycCnt_r + 9'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      currentLimitScale <= `BSS_CURRENT_LIMIT_SETTING_25;
      doubleMinOff <= 1'b0;
      senseOffsetOn <= 1'b0;
    end
    else
    begin
      currentLimitScale <= (state_r == BSS_RUN) ? `BSS_CURRENT_LIMIT_SETTING_100 : phase_r;
      doubleMinOff <= (state_r == BSS_SOFT) && (phase_r == 2'h0);
      senseOffsetOn <= (state_r == BSS_SOFT) && (phase_r == 2'h0);
    end
  end

  // ==========================================================
  // output-ok with qualification filter
  assign okTarget = (state_r == BSS_RUN) && !outOfWindow && outputAt90;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      okCnt_r <= 16'h0;
      outputOkFlag <= 1'b0;
    end
    else if (state_r != BSS_RUN || ovNxt || uvNxt)
    begin
      okCnt_r <= 16'h0;
      outputOkFlag <= 1'b0;
    end
    else if (okTarget == outputOkFlag)
      okCnt_r <= 16'h0;
    else if (okCnt_r == 16'(QUAL_CYC - 1))
    begin
      okCnt_r <= 16'h0;
      outputOkFlag <= okTarget;
    end
    else
      okCnt_r <= okCnt_r + 16'h1;
  end

  // ==========================================================
  // gate drive sequencing, dead time and negative current retry
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive_r <= BSS_OFF;
      offCnt_r <= 16'h0;
      nocWait_r <= 1'b0;
      nocSense_r <= 1'b0;
      nocCnt_r <= 16'h0;
      firstPulse_r <= 1'b1;
    end
    else if (state_r != BSS_SOFT && state_r != BSS_RUN)
    begin
      drive_r <= BSS_OFF;
      nocWait_r <= 1'b0;
      nocSense_r <= 1'b0;
      firstPulse_r <= 1'b1;
    end
    else
    begin
      case (drive_r)
        BSS_OFF:
          if (phaseBelow1v)
          begin
            drive_r <= BSS_LOW;
            firstPulse_r <= 1'b0;
          end
        BSS_LOW:
          if (nocWait_r)
          begin
            // low-side stays off through the retry wait
            if (nocCnt_r >= 16'(`BSS_NOC_WAIT_CYC - 1))
            begin
              nocWait_r <= 1'b0;
              nocSense_r <= 1'b1;
              nocCnt_r <= 16'h0;
            end
            else
              nocCnt_r <= nocCnt_r + 16'h1;
          end
          else if (phaseNegOc)
          begin
            nocWait_r <= 1'b1;
            nocSense_r <= 1'b0;
            nocCnt_r <= 16'h0;
          end
          else if (nocSense_r)
          begin
            if (nocCnt_r >= 16'(`BSS_NOC_SENSE_CYC - 1))
              nocSense_r <= 1'b0;
            else
              nocCnt_r <= nocCnt_r + 16'h1;
          end
          else
          begin
            if (offCnt_r != 16'h0)
              offCnt_r <= offCnt_r - 16'h1;
            else if (onTimeRequest && !valleyOverLimit && !lowGateAbove1v && !firstPulse_r)
              drive_r <= BSS_HIGH;
          end
        BSS_HIGH:
          if (onTimeDone)
          begin
            drive_r <= BSS_OFF;
            offCnt_r <= doubleMinOff ? 16'(2 * `BSS_MINOFF_CYC) : 16'(`BSS_MINOFF_CYC);
          end
        default:
          drive_r <= BSS_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      highGateDrive <= 1'b0;
      highGateStrong <= 1'b0;
      lowGateDrive <= 1'b0;
      drivesTriState <= 1'b1;
      softDischarge <= 1'b0;
    end
    else
    begin
      highGateDrive <= running && !ovNxt && !uvNxt && drive_r == BSS_HIGH;
      highGateStrong <= running && !ovNxt && !uvNxt && drive_r == BSS_HIGH
        && phaseAbove1v5;
      lowGateDrive <= ovNxt
        || (running && !uvNxt && drive_r == BSS_LOW && !nocWait_r && !hsHandoff
        && !(phaseNegOc && !nocSense_r));
      drivesTriState <= (state_r == BSS_LOCK) || uvNxt;
      softDischarge <= (state_r == BSS_IDLE) && !enablePin && supplyPorOk;
    end
  end
endmodule
`default_nettype wire

// ---- bss_sequencer_asserts.sv ----
// port level properties of the sequencer
`timescale 1ns/1ns
`default_nettype none
module bss_sequencer_asserts
#(
  parameter int QUAL_CYC = 8
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic supplyAboveOff,
  input wire logic enablePin,
  input wire logic outOfWindow,
  input wire logic outputAt90,
  input wire logic highGateDrive,
  input wire logic highGateStrong,
  input wire logic lowGateDrive,
  input wire logic drivesTriState,
  input wire logic outputOkFlag,
  input wire logic [1:0] currentLimitScale,
  input wire logic senseOffsetOn,
  input wire logic ovLatched,
  input wire logic uvLatched
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  int okRun_r;
  // saturating, so a long good stretch never wraps to zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      okRun_r <= 0;
    else if (outOfWindow || !outputAt90)
      okRun_r <= 0;
    else if (okRun_r < 1000)
      okRun_r <= okRun_r + 1;
  end
  property p_noOverlap;
    !(highGateDrive && lowGateDrive);
  endproperty
  a_noOverlap: assert property (p_noOverlap) else $error("both gates on");
  property p_strong;
    $rose(highGateStrong) |-> highGateDrive;
  endproperty
  a_strong: assert property (p_strong) else $error("strong pull-up alone");
  property p_okGate;
    outputOkFlag |-> currentLimitScale == 2'h3 && !uvLatched && !ovLatched;
  endproperty
  a_okGate: assert property (p_okGate) else $error("output ok too early");
  property p_okQual;
    $rose(outputOkFlag) |-> okRun_r >= QUAL_CYC - 2;
  endproperty
  a_okQual: assert property (p_okQual) else $error("output ok not filtered");
  property p_ovDrive;
    ovLatched |-> lowGateDrive && !highGateDrive;
  endproperty
  a_ovDrive: assert property (p_ovDrive) else $error("over-voltage drive wrong");
  property p_uvTri;
    uvLatched |-> drivesTriState && !highGateDrive && !lowGateDrive;
  endproperty
  a_uvTri: assert property (p_uvTri) else $error("under-voltage not tri-stated");
  property p_offset;
    senseOffsetOn |-> currentLimitScale == 2'h0;
  endproperty
  a_offset: assert property (p_offset) else $error("offset outside first phase");
  property p_supplyDrop;
    !supplyAboveOff |-> ##[1:3] (drivesTriState && !lowGateDrive);
  endproperty
  a_supplyDrop: assert property (p_supplyDrop) else $error("no tri-state on supply drop");
  property p_holdFault;
    (ovLatched || uvLatched) && enablePin && $past(enablePin) && $past(enablePin, 2)
      && supplyAboveOff && $past(supplyAboveOff) && $past(supplyAboveOff, 2)
      |=> ovLatched || uvLatched;
  endproperty
  a_holdFault: assert property (p_holdFault) else $error("fault cleared without toggle");
  c_ov: cover property ($rose(ovLatched));
  c_uv: cover property ($rose(uvLatched));
  c_ok: cover property ($rose(outputOkFlag));
  c_strong: cover property ($rose(highGateStrong));
endmodule
`default_nettype wire

// ---- bss_sequencer_tb.sv ----
// self-checking bench for the soft-start and fault sequencer
`timescale 1ns/1ns
`default_nettype none
module bss_sequencer_tb;
  localparam int QC = 8;
  localparam int PC = 3;
  logic clk = 1'b0, reset_n = 1'b0, supplyPorOk = 1'b0, supplyAboveOn = 1'b0;
  logic supplyAboveOff = 1'b0, enablePin = 1'b0, onTimeRequest = 1'b0, onTimeDone = 1'b0;
  logic overVoltage = 1'b0, underVoltage = 1'b0, outOfWindow = 1'b0, outputAt90 = 1'b0;
  logic phaseNegOc = 1'b0, valleyOverLimit = 1'b0, phaseBelow1v, phaseAbove1v5, lowGateAbove1v;
  logic highGateDrive, highGateStrong, lowGateDrive, drivesTriState, outputOkFlag;
  logic softDischarge, biasOn, doubleMinOff, senseOffsetOn, ovLatched, uvLatched;
  logic [1:0] currentLimitScale;
  int failures = 0, num_checks = 0;
  // bit 0 tri, 1 low, 2 high, 3 uv, 4 ov, 5 ok
  wire logic [5:0] obs = {outputOkFlag, ovLatched, uvLatched, highGateDrive, lowGateDrive,
    drivesTriState};
  bss_sequencer #(.QUAL_CYC(QC), .PHASE_CYC(PC)) i_dut (.clk, .reset_n, .supplyPorOk,
    .supplyAboveOn, .supplyAboveOff, .enablePin, .onTimeRequest, .onTimeDone, .overVoltage,
    .underVoltage, .outOfWindow, .outputAt90, .phaseNegOc, .phaseBelow1v, .phaseAbove1v5,
    .lowGateAbove1v, .valleyOverLimit, .highGateDrive, .highGateStrong, .lowGateDrive,
    .drivesTriState, .outputOkFlag, .softDischarge, .biasOn, .currentLimitScale, .doubleMinOff,
    .senseOffsetOn, .ovLatched, .uvLatched);
  bss_stage_model i_stage (.clk, .highGateDrive, .lowGateDrive, .phaseBelow1v, .phaseAbove1v5,
    .lowGateAbove1v);
  initial
  begin
    forever #2 clk = ~clk;
  end
  task give_verdict();
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // a bound that runs out ends the run at once
  task waitBit(input int idx, input logic val, input int lim);
    for (int i = 0; i < lim && obs[idx] !== val; i++)
      step(1);
    if (obs[idx] !== val)
    begin
      failures++;
      give_verdict();
    end
  endtask
  task sw();
    onTimeRequest = 1'b1;
    waitBit(2, 1'b1, 400);
    onTimeRequest = 1'b0;
    step(3);
    chk({highGateDrive, highGateStrong, lowGateDrive, drivesTriState}, 4'hc);
    onTimeDone = 1'b1;
    step(2);
    onTimeDone = 1'b0;
  endtask
  // ==========================================
  // scenarios
  initial
  begin
    int p, c;
    step(10);
    chk({drivesTriState, outputOkFlag, currentLimitScale}, 4'h8);
    reset_n = 1'b1;
    step(3);
    chk({biasOn, lowGateDrive, highGateDrive, drivesTriState}, 4'h1);
    supplyPorOk = 1'b1;
    supplyAboveOff = 1'b1;
    step(3);
    chk({biasOn, lowGateDrive, highGateDrive, drivesTriState}, 4'h9);
    supplyAboveOn = 1'b1;
    step(5);
    chk({biasOn, softDischarge, lowGateDrive, highGateDrive}, 4'hc);
    enablePin = 1'b1;
    outputAt90 = 1'b1;
    waitBit(1, 1'b1, 20);
    chk({highGateDrive, senseOffsetOn, doubleMinOff, softDischarge}, 4'h6);
    for (p = 0; p < 4; p++)
      for (c = 0; c < PC; c++)
      begin
        chk({senseOffsetOn, doubleMinOff, currentLimitScale}, {p == 0, p == 0, p[1:0]});
        sw();
      end
    chk({outputOkFlag, currentLimitScale, uvLatched}, 4'h6);
    waitBit(5, 1'b1, 3 * QC);
    outOfWindow = 1'b1;
    step(3);
    outOfWindow = 1'b0;
    step(QC + 4);
    outOfWindow = 1'b1;
    step(QC - 2);
    chk({outputOkFlag, ovLatched, uvLatched, lowGateDrive}, 4'h9);
    waitBit(5, 1'b0, 2 * QC);
    outOfWindow = 1'b0;
    waitBit(5, 1'b1, 2 * QC);
    phaseNegOc = 1'b1;
    step(3);
    chk({lowGateDrive, highGateDrive, drivesTriState, ovLatched}, 4'h0);
    step(580);
    chk({lowGateDrive, highGateDrive, drivesTriState, ovLatched}, 4'h0);
    waitBit(1, 1'b1, 100);
    waitBit(1, 1'b0, 100);
    phaseNegOc = 1'b0;
    waitBit(1, 1'b1, 700);
    underVoltage = 1'b1;
    step(QC - 2);
    chk({uvLatched, drivesTriState, lowGateDrive, highGateDrive}, 4'h2);
    waitBit(3, 1'b1, 2 * QC);
    underVoltage = 1'b0;
    step(5);
    chk({uvLatched, drivesTriState, lowGateDrive, highGateDrive}, 4'hc);
    enablePin = 1'b0;
    step(4);
    chk({uvLatched, softDischarge, lowGateDrive, highGateDrive}, 4'h4);
    enablePin = 1'b1;
    waitBit(1, 1'b1, 20);
    chk({senseOffsetOn, currentLimitScale, highGateDrive}, 4'h8);
    valleyOverLimit = 1'b1;
    onTimeRequest = 1'b1;
    step(300);
    chk({highGateDrive, ovLatched, uvLatched, outputOkFlag}, 4'h0);
    valleyOverLimit = 1'b0;
    sw();
    overVoltage = 1'b1;
    step(QC - 2);
    chk({ovLatched, uvLatched, highGateDrive, drivesTriState}, 4'h0);
    waitBit(4, 1'b1, 2 * QC);
    overVoltage = 1'b0;
    onTimeRequest = 1'b1;
    step(20);
    chk({ovLatched, lowGateDrive, highGateDrive, drivesTriState}, 4'hc);
    onTimeRequest = 1'b0;
    supplyAboveOn = 1'b0;
    supplyAboveOff = 1'b0;
    step(4);
    chk({ovLatched, lowGateDrive, highGateDrive, drivesTriState}, 4'h1);
    supplyAboveOff = 1'b1;
    supplyAboveOn = 1'b1;
    waitBit(1, 1'b1, 20);
    chk({ovLatched, currentLimitScale, highGateDrive}, 4'h0);
    give_verdict();
  end
endmodule
bind bss_sequencer bss_sequencer_asserts #(.QUAL_CYC(QUAL_CYC)) i_chk (.clk, .reset_n,
  .supplyAboveOff, .enablePin, .outOfWindow, .outputAt90, .highGateDrive, .highGateStrong,
  .lowGateDrive, .drivesTriState, .outputOkFlag, .currentLimitScale, .senseOffsetOn,
  .ovLatched, .uvLatched);
`default_nettype wire

// ---- bss_stage_model.sv ----
// power stage stand-in: gate and phase node comparator flags
`timescale 1ns/1ns
`default_nettype none
module bss_stage_model
(
  input wire logic clk,
  input wire logic highGateDrive,
  input wire logic lowGateDrive,
  output logic phaseBelow1v,
  output logic phaseAbove1v5,
  output logic lowGateAbove1v
);
  logic [1:0] hiDly_r = 2'h0;
  logic [1:0] loDly_r = 2'h0;
  // gates take two cycles to swing, so the dead time is really waited for
  always_ff @(posedge clk)
  begin
    hiDly_r <= {hiDly_r[0], highGateDrive};
    loDly_r <= {loDly_r[0], lowGateDrive};
  end
  assign lowGateAbove1v = |loDly_r;
  assign phaseBelow1v = ~|hiDly_r;
  assign phaseAbove1v5 = &hiDly_r;
endmodule
`default_nettype wire
